// File: design/icb_top.v
// two-wire bus controller: flags, requests, bit sync, bus state
// assumes an axi4-lite master on clk_sys and open-drain pads
//
// Summary of operation
// - tx-empty, tx-end, rx-full requests: flag and enable.
// - stop request from stop flag; shared request from no-ack or arb-lost.
// - writing transmit data clears tx-empty and tx-end flags.
// - reading receive data clears the rx-full flag.
// - master waits for real scl high after release, bit by bit.
// - monitor time 7.5, 17.5 or 41.5 cycles from clock select.
// - other clock-select codes give 19.5, 85.5 or 41.5 cycles.
// - slave stores every byte, sets rx-full; match flagged apart.
// - disable or soft reset keeps busy and stop flags.
// - start on the bus sets the busy flag.
// - stop on the bus clears the busy flag.
// - busy 1, control 0: start if master transmit, bus not busy and lines high.
// - busy 0, control 0: stop while only we hold scl low.
// - tx-end sets at ninth rise when tx-empty is set.
// - rx-full sets at ninth rise when a frame completes.
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "icb_regs.vh"
module icb_top #(
    parameter AW = 8
) (
    input  wire          clk_sys,
    input  wire          rst_n,
    input  wire [AW-1:0] s_axi_awaddr,
    input  wire          s_axi_awvalid,
    output reg           s_axi_awready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output reg           s_axi_wready,
    output reg  [1:0]    s_axi_bresp,
    output reg           s_axi_bvalid,
    input  wire          s_axi_bready,
    input  wire [AW-1:0] s_axi_araddr,
    input  wire          s_axi_arvalid,
    output reg           s_axi_arready,
    output reg  [31:0]   s_axi_rdata,
    output reg  [1:0]    s_axi_rresp,
    output reg           s_axi_rvalid,
    input  wire          s_axi_rready,
    input  wire          scl_i,
    output reg           scl_o,
    output reg           scl_oe_n,
    input  wire          sda_i,
    output reg           sda_o,
    output reg           sda_oe_n,
    output reg           tx_empty_irq,
    output reg           tx_end_irq,
    output reg           rx_full_irq,
    output reg           stop_seen_irq,
    output reg           nack_shared_irq
);
    localparam S_IDLE = 3'h0;
    localparam S_STA  = 3'h1;
    localparam S_HOLD = 3'h2;
    localparam S_LOW  = 3'h3;
    localparam S_HIGH = 3'h4;
    localparam S_STP1 = 3'h5;
    localparam S_STP2 = 3'h6;

    function mapped;
        input [AW-1:0] a;
        begin
            case (a)
                `ICB_A_CTRL1, `ICB_A_CTRL2, `ICB_A_MODE, `ICB_A_IEN,
                `ICB_A_STAT, `ICB_A_TXD, `ICB_A_RXD,
                `ICB_A_SADR: mapped = 1'b1;
                default:     mapped = 1'b0;
            endcase
        end
    endfunction

    function [7:0] mon_half;
        input [3:0] cs;
        begin
            case (cs[3:2])
                2'b00:   mon_half = `ICB_MON2_7P5;
                2'b10:   mon_half = `ICB_MON2_17P5;
                2'b01:   mon_half = (cs[1:0] == 2'b00) ? `ICB_MON2_41P5
                                                       : `ICB_MON2_19P5;
                default: mon_half = cs[1] ? `ICB_MON2_41P5
                                          : `ICB_MON2_85P5;
            endcase
        end
    endfunction

    reg  [7:0] ctrl1_q;
    reg  [7:0] mode_q;
    reg  [7:0] ien_q;
    reg  [6:0] sadr_q;
    reg  [7:0] txd_q;
    reg  [7:0] rxd_q;
    reg        busy_q;
    reg        txe_q;
    reg        tx_end_flag_q;
    reg        rxf_q;
    reg        stop_q;
    reg        nack_q;
    reg        al_q;
    reg        aas_q;
    reg        sta_pend_q;
    reg        stp_pend_q;
    reg  [2:0] st_q;
    reg  [7:0] cnt_q;
    reg  [3:0] bit_q;
    reg  [7:0] sh_q;
    reg        mon_go_q;
    reg        scl_p_q;
    reg        sda_p_q;
    reg        sact_q;
    reg        sfirst_q;
    reg  [3:0] sbit_q;
    reg  [7:0] ssh_q;
    reg  [7:0] rmux;
    wire [1:0] line_s;
    wire       scl_s;
    wire       sda_s;
    wire       mon_done;
    wire [7:0] mon_cyc;
    wire       wr_en;
    wire       wr_ok;
    wire       rd_en;
    wire       tx_wr;
    wire       tx;
    wire       eng_rst;
    wire       start_det;
    wire       stop_det;
    wire       scl_rise;

    icb_sync #(.W(2)) u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .d       ({scl_i, sda_i}),
        .q       (line_s)
    );

    icb_scl_mon u_mon (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .go      (mon_go_q),
        .scl_hi  (scl_s),
        .lim     (mon_cyc),
        .done    (mon_done)
    );

    assign scl_s     = line_s[1];
    assign sda_s     = line_s[0];
    // round up
    assign mon_cyc   = (mon_half(ctrl1_q[3:0]) + 8'h01) >> 1;
    assign wr_en     = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
                       & ~s_axi_bvalid;
    assign wr_ok     = wr_en & s_axi_wstrb[0];
    assign rd_en     = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
    assign tx_wr     = wr_ok && (s_axi_awaddr == `ICB_A_TXD);
    assign tx        = ctrl1_q[`ICB_B_TRANSMIT];
    assign eng_rst   = ~ctrl1_q[`ICB_B_ENABLE]
                       | (wr_ok && (s_axi_awaddr == `ICB_A_CTRL2)
                          && s_axi_wdata[`ICB_B_SRST]);
    assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;
    assign scl_rise  = scl_s & ~scl_p_q;

    always @* begin
        case (s_axi_araddr)
            `ICB_A_CTRL1: rmux = ctrl1_q;
            `ICB_A_CTRL2: rmux = {busy_q, 6'h00, scl_s};
            `ICB_A_MODE:  rmux = mode_q;
            `ICB_A_IEN:   rmux = ien_q;
            `ICB_A_STAT:  rmux = {txe_q, tx_end_flag_q, rxf_q, stop_q,
                                  nack_q, al_q, aas_q, 1'b0};
            `ICB_A_TXD:   rmux = txd_q;
            `ICB_A_RXD:   rmux = rxd_q;
            `ICB_A_SADR:  rmux = {1'b0, sadr_q};
            default:      rmux = `ICB_RST_BYTE;
        endcase
    end

    // axi4-lite: ready pulse, answer next cycle
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ICB_RESP_OK;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `ICB_RESP_OK;
            s_axi_rdata   <= 32'h0000_0000;
        end else begin
            s_axi_awready <= wr_en;
            s_axi_wready  <= wr_en;
            if (wr_en)
                s_axi_bresp <= mapped(s_axi_awaddr) ? `ICB_RESP_OK
                                                    : `ICB_RESP_ERR;
            if (s_axi_awready)
                s_axi_bvalid <= 1'b1;
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            s_axi_arready <= rd_en;
            if (rd_en) begin
                s_axi_rdata <= {24'h00_0000, rmux};
                s_axi_rresp <= mapped(s_axi_araddr) ? `ICB_RESP_OK
                                                    : `ICB_RESP_ERR;
            end
            if (s_axi_arready)
                s_axi_rvalid <= 1'b1;
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // registers, flags and bit engine
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl1_q <= `ICB_RST_BYTE;
            mode_q <= `ICB_RST_BYTE;
            ien_q <= `ICB_RST_BYTE;
            sadr_q <= `ICB_RST_ADDR;
            txd_q <= `ICB_RST_BYTE;
            rxd_q <= `ICB_RST_BYTE;
            {busy_q, txe_q, tx_end_flag_q, rxf_q} <= 4'h0;
            {stop_q, nack_q, al_q, aas_q} <= 4'h0;
            {sta_pend_q, stp_pend_q, mon_go_q} <= 3'h0;
            {scl_p_q, sda_p_q} <= 2'b11;
            {sact_q, sfirst_q} <= 2'b00;
            {scl_oe_n, sda_oe_n, scl_o, sda_o} <= 4'hc;
            st_q <= S_IDLE;
            cnt_q <= 8'h00;
            bit_q <= 4'h0;
            sbit_q <= 4'h0;
            sh_q <= `ICB_RST_BYTE;
            ssh_q <= `ICB_RST_BYTE;
        end else begin
            mon_go_q <= 1'b0;
            if (wr_ok) begin
                case (s_axi_awaddr)
                    `ICB_A_CTRL1: ctrl1_q <= s_axi_wdata[7:0];
                    `ICB_A_CTRL2: begin
                        if (!s_axi_wdata[`ICB_B_SSC]) begin
                            sta_pend_q <= s_axi_wdata[`ICB_B_BUSY];
                            stp_pend_q <= ~s_axi_wdata[`ICB_B_BUSY];
                        end
                    end
                    `ICB_A_MODE: mode_q <= s_axi_wdata[7:0];
                    `ICB_A_IEN:  ien_q <= s_axi_wdata[7:0];
                    `ICB_A_STAT: begin
                        txe_q  <= txe_q & s_axi_wdata[`ICB_S_TXE];
                        tx_end_flag_q <= tx_end_flag_q & s_axi_wdata[`ICB_S_TX_END_FLAG];
                        rxf_q  <= rxf_q & s_axi_wdata[`ICB_S_RXF];
                        stop_q <= stop_q & s_axi_wdata[`ICB_S_STOP];
                        nack_q <= nack_q & s_axi_wdata[`ICB_S_NACK];
                        al_q   <= al_q & s_axi_wdata[`ICB_S_AL];
                        aas_q  <= aas_q & s_axi_wdata[`ICB_S_AAS];
                    end
                    `ICB_A_TXD: begin
                        txd_q  <= s_axi_wdata[7:0];
                        txe_q  <= 1'b0;
                        tx_end_flag_q <= 1'b0;
                    end
                    `ICB_A_SADR: sadr_q <= s_axi_wdata[6:0];
                    default: ;
                endcase
            end
            if (rd_en && (s_axi_araddr == `ICB_A_RXD))
                rxf_q <= 1'b0;
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
            if (start_det)
                busy_q <= 1'b1;
            if (stop_det) begin
                busy_q <= 1'b0;
                stop_q <= 1'b1;
            end
            // slave receive keeps every byte
            if (start_det) begin
                sact_q <= 1'b1;
                sfirst_q <= 1'b1;
                sbit_q <= 4'h0;
            end else if (stop_det) begin
                sact_q <= 1'b0;
            end else if (scl_rise && sact_q && ~ctrl1_q[`ICB_B_MASTER]
                         && ctrl1_q[`ICB_B_ENABLE]) begin
                if (sbit_q == `ICB_NINTH) begin
                    rxd_q <= ssh_q;
                    rxf_q <= 1'b1;
                    if (sfirst_q)
                        aas_q <= (ssh_q[7:1] == sadr_q);
                    sfirst_q <= 1'b0;
                    sbit_q <= 4'h0;
                end else begin
                    ssh_q <= {ssh_q[6:0], sda_s};
                    sbit_q <= sbit_q + 4'h1;
                end
            end
            // engine reset keeps busy and stop
            if (eng_rst) begin
                st_q <= S_IDLE;
                scl_oe_n <= 1'b1;
                sda_oe_n <= 1'b1;
                sta_pend_q <= 1'b0;
                stp_pend_q <= 1'b0;
            end else begin
                case (st_q)
                    S_IDLE: begin
                        stp_pend_q <= 1'b0;
                        if (sta_pend_q) begin
                            sta_pend_q <= 1'b0;
                            if (ctrl1_q[`ICB_B_MASTER] && tx && scl_s
                                && sda_s && !busy_q) begin
                                sda_oe_n <= 1'b0;
                                cnt_q <= 8'h00;
                                st_q <= S_STA;
                            end
                        end
                    end
                    S_STA: begin
                        if (cnt_q == mon_cyc) begin
                            scl_oe_n <= 1'b0;
                            txe_q <= 1'b1;
                            st_q <= S_HOLD;
                        end else begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                    end
                    S_HOLD: begin
                        sta_pend_q <= 1'b0;
                        cnt_q <= 8'h00;
                        bit_q <= 4'h0;
                        if (stp_pend_q) begin
                            stp_pend_q <= 1'b0;
                            sda_oe_n <= 1'b0;
                            st_q <= S_STP1;
                        end else if (tx && !txe_q) begin
                            sh_q <= txd_q;
                            txe_q <= ~tx_wr;
                            st_q <= S_LOW;
                        end else if (!tx && !rxf_q) begin
                            sh_q <= 8'h00;
                            st_q <= S_LOW;
                        end
                    end
                    S_LOW: begin
                        if (cnt_q == 8'h00) begin
                            if (bit_q == `ICB_NINTH)
                                sda_oe_n <= tx | mode_q[`ICB_B_ACKBIT];
                            else
                                sda_oe_n <= ~tx | sh_q[7];
                        end
                        if (cnt_q == mon_cyc) begin
                            scl_oe_n <= 1'b1;
                            mon_go_q <= 1'b1;
                            st_q <= S_HIGH;
                        end else begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                    end
                    S_HIGH: begin
                        if (scl_rise && (bit_q == `ICB_NINTH)) begin
                            if (tx && txe_q)
                                tx_end_flag_q <= 1'b1;
                            if (!tx) begin
                                rxd_q <= sh_q;
                                rxf_q <= 1'b1;
                            end
                        end
                        if (mon_done) begin
                            scl_oe_n <= 1'b0;
                            cnt_q <= 8'h00;
                            if (bit_q == `ICB_NINTH) begin
                                if (tx && sda_s)
                                    nack_q <= 1'b1;
                                sda_oe_n <= 1'b1;
                                st_q <= S_HOLD;
                            end else if (tx && sh_q[7] && !sda_s) begin
                                al_q <= 1'b1;
                                scl_oe_n <= 1'b1;
                                sda_oe_n <= 1'b1;
                                ctrl1_q[`ICB_B_MASTER] <= 1'b0;
                                st_q <= S_IDLE;
                            end else begin
                                sh_q <= {sh_q[6:0], sda_s};
                                bit_q <= bit_q + 4'h1;
                                st_q <= S_LOW;
                            end
                        end
                    end
                    S_STP1: begin
                        if (cnt_q == mon_cyc) begin
                            scl_oe_n <= 1'b1;
                            mon_go_q <= 1'b1;
                            st_q <= S_STP2;
                        end else begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                    end
                    S_STP2: begin
                        if (mon_done) begin
                            sda_oe_n <= 1'b1;
                            ctrl1_q[`ICB_B_MASTER] <= 1'b0;
                            st_q <= S_IDLE;
                        end
                    end
                    default: st_q <= S_IDLE;
                endcase
            end
        end
    end

    // request levels
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {tx_empty_irq, tx_end_irq, rx_full_irq} <= 3'h0;
            {stop_seen_irq, nack_shared_irq} <= 2'h0;
        end else begin
            tx_empty_irq <= txe_q & ien_q[`ICB_S_TXE];
            tx_end_irq <= tx_end_flag_q & ien_q[`ICB_S_TX_END_FLAG];
            rx_full_irq <= rxf_q & ien_q[`ICB_S_RXF];
            stop_seen_irq <= stop_q & ien_q[`ICB_S_STOP];
            nack_shared_irq <= (nack_q | al_q)
                               & ien_q[`ICB_S_NACK];
        end
    end
endmodule // icb_top

// File: design/icb_regs.vh
// register map, fields, reset values and timing for the bus block
// assumes 32-bit axi4-lite data, each register in a word's low byte
`ifndef ICB_REGS_VH
`define ICB_REGS_VH

// byte addresses
`define ICB_A_CTRL1     8'h00
`define ICB_A_CTRL2     8'h04
`define ICB_A_MODE      8'h08
`define ICB_A_IEN       8'h0c
`define ICB_A_STAT      8'h10
`define ICB_A_TXD       8'h14
`define ICB_A_RXD       8'h18
`define ICB_A_SADR      8'h1c

// ctrl_reg_one fields
`define ICB_B_ENABLE    7
`define ICB_B_MASTER    5
`define ICB_B_TRANSMIT  4

// ctrl_reg_two fields
`define ICB_B_BUSY      7
`define ICB_B_SSC       6
`define ICB_B_SRST      1

// bus_mode_reg fields
`define ICB_B_WAIT      6
`define ICB_B_ACKBIT    0

// status and enable fields
`define ICB_S_TXE       7
`define ICB_S_TX_END_FLAG      6
`define ICB_S_RXF       5
`define ICB_S_STOP      4
`define ICB_S_NACK      3
`define ICB_S_AL        2
`define ICB_S_AAS       1

// reset values
`define ICB_RST_BYTE    8'h00
`define ICB_RST_ADDR    7'h00

// scl monitor times, in half system cycles
`define ICB_MON2_7P5    8'h0f
`define ICB_MON2_17P5   8'h23
`define ICB_MON2_19P5   8'h27
`define ICB_MON2_41P5   8'h53
`define ICB_MON2_85P5   8'hab

// ninth clock index, axi responses
`define ICB_NINTH       4'h8
`define ICB_RESP_OK     2'h0
`define ICB_RESP_ERR    2'h2

`endif

// File: design/icb_sync.v
// two-flop synchroniser and match filter for the bus lines
// assumes idle-high open-drain lines
`timescale 1ns/1ps
module icb_sync #(
    parameter W = 2
) (
    input  wire         clk_sys,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= {W{1'b1}};
            s2_q <= {W{1'b1}};
            s3_q <= {W{1'b1}};
            q    <= {W{1'b1}};
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // pass only when two stages agree
            q    <= (q & ~(s2_q ~^ s3_q)) | (s2_q & (s2_q ~^ s3_q));
        end
    end
endmodule // icb_sync

// File: design/icb_scl_mon.v
// scl high-time monitor: armed on release, counts while scl is high
// assumes scl_hi is already synchronised to clk_sys
`timescale 1ns/1ps
module icb_scl_mon (
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire       go,
    input  wire       scl_hi,
    input  wire [7:0] lim,
    output reg        done
);
    reg       arm_q;
    reg [7:0] cnt_q;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            arm_q <= 1'b0;
            cnt_q <= 8'h00;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (go) begin
                arm_q <= 1'b1;
                cnt_q <= 8'h00;
            end else if (arm_q && scl_hi) begin
                if (cnt_q == lim - 8'h01) begin
                    arm_q <= 1'b0;
                    done  <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
        end
    end
endmodule // icb_scl_mon

// File: tb/icb_props.sv
// checker for icb_top: bit sync, start, stop, request drops
// assumes it is bound into icb_top and sees only its ports
`timescale 1ns/1ps
module icb_props (
    input wire clk_sys,
    input wire rst_n,
    input wire s_axi_awvalid,
    input wire s_axi_wvalid,
    input wire s_axi_awready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire scl_i,
    input wire scl_oe_n,
    input wire sda_oe_n,
    input wire tx_end_irq,
    input wire rx_full_irq,
    input wire stop_seen_irq,
    input wire nack_shared_irq
);
    logic [3:0] age_q;
    wire        acc = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
                    & ~s_axi_bvalid
                    | s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) age_q <= 4'hf;
        else if (acc) age_q <= 4'h0;
        else if (age_q != 4'hf) age_q <= age_q + 4'h1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence start_s;
        $fell(sda_oe_n) && $stable(scl_oe_n) && scl_oe_n;
    endsequence
    sequence stop_s;
        $rose(sda_oe_n) && $stable(scl_oe_n) && scl_oe_n;
    endsequence
    low_hold_a: assert property ($fell(scl_oe_n) |-> !scl_oe_n [*8])
        else $error("low short");
    high_time_a: assert property ($rose(scl_i) && scl_oe_n
        |=> scl_oe_n [*8]) else $error("high short");
    stretch_wait_a: assert property (scl_oe_n && !scl_i |=> scl_oe_n)
        else $error("pulled in stretch");
    start_seq_a: assert property (start_s |-> ##[1:100] $fell(scl_oe_n))
        else $error("no clock");
    stop_seq_a: assert property (stop_s
        |=> (scl_oe_n && sda_oe_n) [*8]) else $error("bus not free");
    tx_drop_a: assert property ($fell(tx_end_irq) |-> age_q <= 4'h3)
        else $error("tx end drop");
    rx_drop_a: assert property ($fell(rx_full_irq) |-> age_q <= 4'h3)
        else $error("rx drop");
    evt_drop_a: assert property ($fell(stop_seen_irq)
        || $fell(nack_shared_irq) |-> age_q <= 4'h3)
        else $error("event drop");
endmodule // icb_props
bind icb_top icb_props u_props (.*);

// File: tb/icb_partner.sv
// bus peer: acks, stretches scl, acts as outside master
// assumes open-drain lines with pull-ups resolved by the bench
`timescale 1ns/1ps
module icb_partner (
    input  wire        clk_sys,
    input  wire        scl,
    input  wire        sda,
    input  wire        ack_en,
    input  wire [7:0]  stretch,
    output wire        scl_rel,
    output wire        sda_rel,
    output logic [7:0] rx_byte,
    output int         hi_cyc
);
    logic       scl_p = 1, sda_p = 1, sda_s = 1, scl_x = 1, sda_x = 1;
    logic [7:0] sh = 0;
    int         bitn = 0, hold = 0, hcnt = 0;
    assign scl_rel = (hold == 0) & scl_x;
    assign sda_rel = sda_s & sda_x;
    always @(posedge clk_sys) begin
        {scl_p, sda_p} <= {scl, sda};
        hcnt <= scl ? hcnt + 1 : 0;
        if (scl && !scl_p) begin
            sh <= {sh[6:0], sda};
            bitn <= bitn + 1;
        end
        if (!scl && scl_p) begin
            hi_cyc <= hcnt;
            hold <= stretch;
            sda_s <= !(ack_en && bitn == 8);
            if (bitn == 8) rx_byte <= sh;
            if (bitn == 9) bitn <= 0;
        end else if (hold > 0) hold <= hold - 1;
        if (scl && scl_p && sda_p && !sda) bitn <= 0;
    end
    task ext_frame(input [7:0] d);
        #1 sda_x = 0;
        #79;
        for (int k = 0; k < 9; k++) begin
            scl_x = 0;
            #40 sda_x = (k < 8) ? d[7-k] : 1'b1;
            #40 scl_x = 1;
            #80;
        end
        scl_x = 0;
        #40 sda_x = 0;
    endtask
    task ext_stop;
        #40 scl_x = 1;
        #80 sda_x = 1;
        #80;
    endtask
endmodule // icb_partner

// File: tb/icb_top_tb.sv
// bench for icb_top: register bus master, slave peer, random bytes
// assumes icb_partner and icb_props compiled alongside
`timescale 1ns/1ps
`include "icb_regs.vh"
module icb_top_tb;
    logic        clk_sys = 0, rst_n = 0, ack_en = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0]  awaddr = 0, araddr = 0, stretch = 0, b, rx_byte;
    logic [31:0] wdata = 0, lfsr = 32'hc36dc31a, rdata, rd_q;
    logic [1:0]  bresp, rresp, rs;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        scl_o, scl_oe_n, sda_o, sda_oe_n, scl_rel, sda_rel;
    logic [4:0]  irq;
    logic [3:0]  c;
    int          hi_cyc, fails = 0, n_compared = 0, i;
    wire         scl = (scl_oe_n | scl_o) & scl_rel;
    wire         sda = (sda_oe_n | sda_o) & sda_rel;
    wire [8:0]   ev = {irq, rvalid, arready, bvalid, awready};
    always #4 clk_sys = ~clk_sys;
    icb_top dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_i(scl),
        .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .tx_empty_irq(irq[0]), .tx_end_irq(irq[1]),
        .rx_full_irq(irq[2]), .stop_seen_irq(irq[3]),
        .nack_shared_irq(irq[4])
    );
    icb_partner peer (
        .clk_sys(clk_sys), .scl(scl), .sda(sda), .ack_en(ack_en),
        .stretch(stretch), .scl_rel(scl_rel), .sda_rel(sda_rel),
        .rx_byte(rx_byte), .hi_cyc(hi_cyc)
    );
    function [31:0] nxt(input [31:0] v);
        nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function int m_of(input [3:0] k);
        m_of = k[3:2] == 2'b00 ? 8 : k[3:2] == 2'b10 ? 18 :
               k[3:2] == 2'b01 ? (k[1:0] == 2'b00 ? 42 : 20) :
               (k[1] ? 42 : 86);
    endfunction
    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wait_on(input int s, input int lim);
        int k;
        for (k = 0; k < lim; k++) begin
            @(negedge clk_sys);
            if (ev[s] === 1'b1) break;
        end
        if (k == lim) begin
            fails++;
            complete_run();
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        {awaddr, wdata, awvalid, wvalid} <= {a, lfsr[31:8], d, 2'b11};
        wait_on(0, 40);
        @(posedge clk_sys);
        {awvalid, wvalid, bready} <= 3'b001;
        wait_on(1, 40);
        rs = bresp;
        @(posedge clk_sys);
        bready <= 0;
        lfsr = nxt(lfsr);
    endtask
    task rd(input [7:0] a, input [31:0] e, input [31:0] mk);
        {araddr, arvalid} <= {a, 1'b1};
        wait_on(2, 40);
        @(posedge clk_sys);
        {arvalid, rready} <= 2'b01;
        wait_on(3, 40);
        {rd_q, rs} = {rdata, rresp};
        @(posedge clk_sys);
        rready <= 0;
        chk("rdata", e, rd_q & mk);
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1;
        @(posedge clk_sys);
        wr(`ICB_A_MODE, 8'h00);
        wr(`ICB_A_CTRL1, 8'h80);
        wr(`ICB_A_IEN, 8'hf8);
        b = {1'b1, lfsr[6:0]};
        peer.ext_frame(b);
        rd(`ICB_A_CTRL2, 32'h80, 32'h81);
        peer.ext_stop();
        wait_on(7, 200);
        rd(`ICB_A_CTRL2, 32'h01, 32'h81);
        rd(`ICB_A_STAT, 32'h30, '1);
        chk("rx irq", 1, irq[2]);
        rd(`ICB_A_RXD, {24'h0, b}, '1);
        repeat (3) @(posedge clk_sys);
        chk("rx irq", 0, irq[2]);
        wr(8'h20, 8'h00);
        chk("bresp", `ICB_RESP_ERR, rs);
        chk("stop irq", 1, irq[3]);
        wr(`ICB_A_STAT, 8'h00);
        for (int k = 0; k < 8; k++) begin
            c = 32'hedc65480 >> (4 * k);
            {ack_en, stretch} <= {lfsr[8] | (k == 0), 2'b00, lfsr[5:0]};
            wr(`ICB_A_CTRL1, {4'hb, c});
            wr(`ICB_A_CTRL2, 8'h80);
            wait_on(4, 400);
            repeat (2) begin
                b = lfsr[7:0];
                wr(`ICB_A_TXD, b);
                chk("tx end irq", 0, irq[1]);
                wait_on(5, 6000);
                chk("peer byte", b, rx_byte);
            end
            chk("scl high", 1, hi_cyc >= m_of(c) && hi_cyc <= m_of(c) + 7);
            chk("nack irq", !ack_en, irq[4]);
            rd(`ICB_A_CTRL2, 0, 0);
            for (i = 0; i < 60 && rd_q[0]; i++) rd(`ICB_A_CTRL2, 0, 0);
            chk("busy", 32'h80, rd_q & 32'h81);
            wr(`ICB_A_CTRL2, 8'h00);
            wait_on(7, 400);
            rd(`ICB_A_CTRL2, 32'h01, 32'h81);
            wr(`ICB_A_STAT, 8'h00);
            repeat (3) @(posedge clk_sys);
            chk("irqs", 4'h0, irq[4:1]);
        end
        complete_run();
    end
endmodule // icb_top_tb
